// >>> logic/strap_cfg_pkg.sv
// Package with types and constants for the reset strap configuration loader.
package strap_cfg_pkg;

    // ****************************************************************
    // Default configuration values (used when override is not asserted)
    // ****************************************************************
    localparam logic DEF_BOOT_LOCATION = 1'h0;  // Internal boot.
    localparam logic DEF_BOOT_WIDTH    = 1'h1;  // 32-bit port.
    localparam logic DEF_PAD_STRENGTH  = 1'h0;  // Default strength.
    localparam logic DEF_LOOP_ENABLE   = 1'h1;
    localparam logic DEF_CLOCK_RATIO   = 1'h1;
    localparam logic DEF_CLOCK_REF     = 1'h1;  // Crystal reference.

    // ****************************************************************
    // Reset values of the configuration outputs
    // ****************************************************************
    localparam logic RST_SELECT_ENABLE = 1'h0;
    localparam logic RST_PORT_WIDTH    = 1'h1;
    localparam logic RST_SECOND_ENABLE = 1'h0;
    localparam logic RST_PAD_DRIVE     = 1'h0;
    localparam logic RST_LOOP_MODE     = 1'h0;
    localparam logic RST_LOOP_SELECT   = 1'h0;
    localparam logic RST_REF_SELECT    = 1'h0;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS     = 20;
    localparam int RELEASE_TIME_NS   = 20;  // One clock-out cycle.
    localparam int RELEASE_CYCLES_I  =
        (RELEASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] RELEASE_CYCLES = RELEASE_CYCLES_I[3:0];

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_RESET   = 2'b00,
        ST_RELEASE = 2'b01,
        ST_RUN     = 2'b10
    } phase_e;

    typedef struct packed {
        logic boot_location_strap;
        logic boot_width_strap;
        logic pad_strength_strap;
        logic clock_reference_strap;
        logic clock_ratio_strap;
        logic loop_enable_pin;
    } straps_s;

    typedef struct packed {
        logic select_enable_flag;   // Boot select control enable.
        logic port_width_flag;      // 1 = 32-bit port.
        logic second_enable_flag;   // Emulation select enable.
    } select_cfg_s;

    typedef struct packed {
        logic loop_mode_flag;
        logic loop_select_flag;
        logic reference_select_flag;
    } clock_cfg_s;

endpackage

// >>> logic/boot_select_decode.sv
// Decoder from boot straps to chip select control bits.
`timescale 1ns/1ns
module boot_select_decode
    import strap_cfg_pkg::*;
(
    input  wire logic        boot_location_i,  // Boot location level
    input  wire logic        boot_width_i,     // Boot width level
    input  wire logic        emulation_i,      // Emulation mode active
    output select_cfg_s      cfg_o             // Decoded select controls
);

    always_comb begin
        if (!boot_location_i) begin
            // Internal boot: boot select off, 32-bit, width ignored.
            cfg_o.select_enable_flag = 1'h0;
            cfg_o.port_width_flag    = 1'h1;
            cfg_o.second_enable_flag = emulation_i;
        end else begin
            cfg_o.select_enable_flag = 1'h1;
            cfg_o.port_width_flag    = boot_width_i;
            cfg_o.second_enable_flag = 1'h0;
        end
    end

endmodule

// >>> logic/clock_mode_decode.sv
// Decoder from clock straps to synthesizer status mode bits.
`timescale 1ns/1ns
module clock_mode_decode
    import strap_cfg_pkg::*;
(
    input  wire logic   loop_enable_i,   // Loop enable level
    input  wire logic   clock_ratio_i,   // Clock ratio strap level
    input  wire logic   clock_ref_i,     // Clock reference strap level
    output clock_cfg_s  cfg_o            // Decoded clock mode
);

    always_comb begin
        cfg_o.loop_mode_flag        = loop_enable_i;
        cfg_o.loop_select_flag      = loop_enable_i & clock_ratio_i;
        cfg_o.reference_select_flag =
            loop_enable_i & clock_ratio_i & clock_ref_i;
    end

endmodule

// >>> logic/reset_strap_config_loader.sv
// Reset strap configuration loader, top level.
// Function
// - Disabled boot select: enable 0, port width 32, second select enable follows emulation.
// - Enabled 16-bit boot select: enable 1, width 0, second enable 0.
// - Enabled 32-bit boot select: enable 1, width 1, second enable 0.
// - Second select enable set only in emulation with internal boot.
// - Select bits keep captured values after reset; software may overwrite.
// - Location strap low: internal boot, 32-bit port, width strap ignored.
// - Location high, width low: external boot, enabled, 16-bit port.
// - Location high, width high: external boot, enabled, 32-bit port.
// - Pad strength strap loads pad drive bit: low default, high full.
// - Software may change pad drive bit any time after the strap pins are released (run phase).
// - Clock mode bits latched in reset, constant until next reset.
// - Loop enable low: external clock mode, synthesizer off.
// - Loop on, ratio low: one-to-one; ratio high, ref low: external ref.
// - Loop, ratio and reference all high: crystal reference mode.
// - Strap values used only when override pin is low in reset.
// - This block never raises an interrupt request.
// - Reset drives every configuration output to its startup value.
// - Without override, defaults drive configuration, data pins ignored.
// - Strap pins stay inputs until a clock-out cycle after reset-out.
`timescale 1ns/1ns
module reset_strap_config_loader
    import strap_cfg_pkg::*;
(
    input  wire logic   clk_i,                   // System clock, 50 MHz
    input  wire logic   rst_n_i,                 // Sync reset, active low
    input  wire logic   reset_out_n_i,           // Reset-out pin level
    input  wire logic   config_override_n_i,     // Override pin, low active
    input  wire logic   emulation_i,             // Emulation mode active
    input  straps_s     straps_i,                // Strap pin levels
    input  wire logic   sel_wr_i,                // Select controls write
    input  select_cfg_s sel_wdata_i,             // Select controls data
    input  wire logic   pad_wr_i,                // Pad drive write
    input  wire logic   pad_wdata_i,             // Pad drive data
    output logic        select_enable_flag_o,    // Boot select enable
    output logic        port_width_flag_o,       // Boot select 32-bit
    output logic        second_enable_flag_o,    // Emulation select enable
    output logic        pad_drive_flag_o,        // Full pad strength
    output logic        loop_mode_flag_o,        // Synthesizer enabled
    output logic        loop_select_flag_o,      // Normal loop mode
    output logic        reference_select_flag_o, // Crystal reference
    output logic        strap_drive_ok_o,        // Data pins may drive
    output logic        irq_o                    // Interrupt, always low
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        phase_e      phase;
        logic [3:0]  release_cnt;
        select_cfg_s sel;
        logic        pad;
        clock_cfg_s  clk_cfg;
        logic        drive_ok;
    } state_s;

    state_s      state;
    state_s      next_state;
    straps_s     eff;
    select_cfg_s sel_dec;
    clock_cfg_s  clk_dec;

    // ****************************************************************
    // Strap selection
    // ****************************************************************
    // Defaults replace the pins entirely when override is not asserted,
    // so floating data pins can never leak into the configuration.
    always_comb begin
        if (!config_override_n_i) begin
            eff = straps_i;
        end else begin
            eff.boot_location_strap   = DEF_BOOT_LOCATION;
            eff.boot_width_strap      = DEF_BOOT_WIDTH;
            eff.pad_strength_strap    = DEF_PAD_STRENGTH;
            eff.clock_reference_strap = DEF_CLOCK_REF;
            eff.clock_ratio_strap     = DEF_CLOCK_RATIO;
            eff.loop_enable_pin       = DEF_LOOP_ENABLE;
        end
    end

    boot_select_decode u_boot (
        .boot_location_i (eff.boot_location_strap),
        .boot_width_i    (eff.boot_width_strap),
        .emulation_i     (emulation_i),
        .cfg_o           (sel_dec)
    );

    clock_mode_decode u_clock (
        .loop_enable_i (eff.loop_enable_pin),
        .clock_ratio_i (eff.clock_ratio_strap),
        .clock_ref_i   (eff.clock_reference_strap),
        .cfg_o         (clk_dec)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_state = state;
        unique case (state.phase)
            ST_RESET: begin
                // Capture every edge while reset-out is low; the value
                // taken on the last such edge is the one that stays.
                if (!reset_out_n_i) begin
                    next_state.sel     = sel_dec;
                    next_state.pad     = eff.pad_strength_strap;
                    next_state.clk_cfg = clk_dec;
                end else begin
                    next_state.phase       = ST_RELEASE;
                    next_state.release_cnt = RELEASE_CYCLES;
                end
            end
            ST_RELEASE: begin
                // Hold the pins as inputs for a clock-out cycle.
                if (state.release_cnt <= 4'h1) begin
                    next_state.phase    = ST_RUN;
                    next_state.drive_ok = 1'h1;
                end else begin
                    next_state.release_cnt = state.release_cnt - 4'h1;
                end
            end
            ST_RUN: begin
                if (sel_wr_i) begin
                    next_state.sel = sel_wdata_i;
                end
                if (pad_wr_i) begin
                    next_state.pad = pad_wdata_i;
                end
            end
            default: begin
                next_state.phase = ST_RESET;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state.phase                     <= ST_RESET;
            state.release_cnt               <= 4'h0;
            state.sel.select_enable_flag    <= RST_SELECT_ENABLE;
            state.sel.port_width_flag       <= RST_PORT_WIDTH;
            state.sel.second_enable_flag    <= RST_SECOND_ENABLE;
            state.pad                       <= RST_PAD_DRIVE;
            state.clk_cfg.loop_mode_flag    <= RST_LOOP_MODE;
            state.clk_cfg.loop_select_flag  <= RST_LOOP_SELECT;
            state.clk_cfg.reference_select_flag <= RST_REF_SELECT;
            state.drive_ok                  <= 1'h0;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign select_enable_flag_o    = state.sel.select_enable_flag;
    assign port_width_flag_o       = state.sel.port_width_flag;
    assign second_enable_flag_o    = state.sel.second_enable_flag;
    assign pad_drive_flag_o        = state.pad;
    assign loop_mode_flag_o        = state.clk_cfg.loop_mode_flag;
    assign loop_select_flag_o      = state.clk_cfg.loop_select_flag;
    assign reference_select_flag_o = state.clk_cfg.reference_select_flag;
    assign strap_drive_ok_o        = state.drive_ok;
    assign irq_o                   = 1'h0;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_clock_mode_held: assert property (
        state.phase != ST_RESET |=> $stable(state.clk_cfg))
        else $error("Clock mode changed after reset.");

    a_capture_defaults: assert property (
        state.phase == ST_RESET && !reset_out_n_i && config_override_n_i
        |=> state.sel.port_width_flag && !state.sel.select_enable_flag)
        else $error("Defaults not applied without override.");

    a_internal_boot: assert property (
        state.phase == ST_RESET && !reset_out_n_i && !config_override_n_i
        && !straps_i.boot_location_strap
        |=> !select_enable_flag_o && port_width_flag_o)
        else $error("Internal boot decode wrong.");

    a_external_width: assert property (
        state.phase == ST_RESET && !reset_out_n_i && !config_override_n_i
        && straps_i.boot_location_strap
        |=> select_enable_flag_o && !second_enable_flag_o
        && port_width_flag_o == $past(straps_i.boot_width_strap))
        else $error("External boot decode wrong.");

    a_second_select: assert property (
        state.phase == ST_RESET && !reset_out_n_i
        |=> second_enable_flag_o ==
            ($past(emulation_i) && !select_enable_flag_o))
        else $error("Second select enable decode wrong.");

    a_pad_strap: assert property (
        state.phase == ST_RESET && !reset_out_n_i && !config_override_n_i
        |=> pad_drive_flag_o == $past(straps_i.pad_strength_strap))
        else $error("Pad drive not loaded from strap.");

    a_loop_off: assert property (
        state.phase == ST_RESET && !reset_out_n_i && !config_override_n_i
        && !straps_i.loop_enable_pin
        |=> !loop_mode_flag_o && !loop_select_flag_o
        && !reference_select_flag_o)
        else $error("External clock mode decode wrong.");

    a_crystal_ref: assert property (
        state.phase == ST_RESET && !reset_out_n_i && !config_override_n_i
        && straps_i.loop_enable_pin && straps_i.clock_ratio_strap
        && straps_i.clock_reference_strap
        |=> loop_mode_flag_o && loop_select_flag_o
        && reference_select_flag_o)
        else $error("Crystal reference decode wrong.");

    a_pins_held: assert property (
        state.phase == ST_RESET && reset_out_n_i
        |-> !strap_drive_ok_o ##1 !strap_drive_ok_o ##1 strap_drive_ok_o)
        else $error("Strap pins released at wrong time.");

    a_no_irq: assert property (
        !irq_o)
        else $error("Interrupt raised.");

    a_pad_write: assert property (
        state.phase == ST_RUN && pad_wr_i
        |=> pad_drive_flag_o == $past(pad_wdata_i))
        else $error("Pad drive write lost.");

    c_override_boot: cover property (
        state.phase == ST_RESET && !config_override_n_i && reset_out_n_i);
    c_default_boot: cover property (
        state.phase == ST_RESET && config_override_n_i && reset_out_n_i);
    c_run_reached: cover property (state.phase == ST_RUN);
    c_sel_write: cover property (state.phase == ST_RUN && sel_wr_i);

endmodule

// >>> verification/strap_pins_model.sv
// Model of the external circuit that drives the strap pins during reset.
`timescale 1ns/1ns
module strap_pins_model
    import strap_cfg_pkg::*;
(
    input  wire logic clk_i,         // System clock
    input  wire logic reset_out_n_i, // Reset-out level, low = asserted
    input  straps_s   value_i,       // Levels to present in reset
    output straps_s   straps_o       // Pin levels seen by the block
);
    straps_s last = 6'h00;
    logic    released = 1'h1;

    // Pins are driven only while reset-out is low and let go on the first
    // edge after it negates; a let-go pin shows the inverse of its last
    // level so a late sample cannot pass by luck.
    always @(posedge clk_i) begin
        if (!reset_out_n_i) begin
            last     <= value_i;
            released <= 1'h0;
        end else begin
            released <= 1'h1;
        end
    end

    assign straps_o = released ? ~last : last;
endmodule

// >>> verification/reset_strap_config_loader_test.sv
// Self-checking testbench of the reset strap configuration loader.
`timescale 1ns/1ns
module reset_strap_config_loader_test
    import strap_cfg_pkg::*;
;
    logic        clk_i = 1'h0;
    logic        rst_n_i = 1'h0;
    logic        reset_out_n_i = 1'h0;
    logic        override_n = 1'h1;
    logic        emulation = 1'h0;
    straps_s     model_value = 6'h00;
    straps_s     straps;
    logic        sel_wr = 1'h0;
    select_cfg_s sel_wdata = 3'h0;
    logic        pad_wr = 1'h0;
    logic        pad_wdata = 1'h0;
    logic        sel_en, width, second, pad, lmode, lsel, lref, ok, irq;
    logic [7:0]  obs;
    logic [7:0]  last_exp;
    int          err_count = 0;
    int          n_tests = 0;
    int          cycles = 0;
    straps_s     table_s [4] = '{6'h1E, 6'h25, 6'h3B, 6'h07};
    logic        table_emu [4] = '{1'h1, 1'h0, 1'h1, 1'h0};

    assign obs = {sel_en, width, second, pad, lmode, lsel, lref, irq};

    strap_pins_model partner (.clk_i(clk_i), .reset_out_n_i(reset_out_n_i),
        .value_i(model_value), .straps_o(straps));

    reset_strap_config_loader DUT (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .reset_out_n_i(reset_out_n_i),
        .config_override_n_i(override_n), .emulation_i(emulation),
        .straps_i(straps), .sel_wr_i(sel_wr), .sel_wdata_i(sel_wdata),
        .pad_wr_i(pad_wr), .pad_wdata_i(pad_wdata),
        .select_enable_flag_o(sel_en), .port_width_flag_o(width),
        .second_enable_flag_o(second), .pad_drive_flag_o(pad),
        .loop_mode_flag_o(lmode), .loop_select_flag_o(lsel),
        .reference_select_flag_o(lref), .strap_drive_ok_o(ok), .irq_o(irq));

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    task automatic results();
        if (err_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // A hung scenario still ends in the closing report.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            results();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask

    // Expected flags plus a zero interrupt bit, from the decode tables.
    function automatic logic [7:0] expect_cfg(input logic ovr_n,
                                              input logic emu,
                                              input straps_s s);
        logic       loc, wid, pds, le, ra, rf;
        logic [2:0] sel, clk;
        loc = ovr_n ? DEF_BOOT_LOCATION : s.boot_location_strap;
        wid = ovr_n ? DEF_BOOT_WIDTH : s.boot_width_strap;
        pds = ovr_n ? DEF_PAD_STRENGTH : s.pad_strength_strap;
        le  = ovr_n ? DEF_LOOP_ENABLE : s.loop_enable_pin;
        ra  = ovr_n ? DEF_CLOCK_RATIO : s.clock_ratio_strap;
        rf  = ovr_n ? DEF_CLOCK_REF : s.clock_reference_strap;
        sel = loc ? {1'h1, wid, 1'h0} : {1'h0, 1'h1, emu};
        clk = !le ? 3'h0 : (!ra ? 3'h4 : (!rf ? 3'h6 : 3'h7));
        return {sel, pds, clk, 1'h0};
    endfunction

    task automatic boot(input logic ovr_n, input logic emu, input straps_s s);
        @(negedge clk_i);
        rst_n_i = 1'h0;
        reset_out_n_i = 1'h0;
        override_n = ovr_n;
        emulation = emu;
        model_value = s;
        last_exp = expect_cfg(ovr_n, emu, s);
        @(negedge clk_i);
        chk("reset values", {RST_SELECT_ENABLE, RST_PORT_WIDTH,
            RST_SECOND_ENABLE, RST_PAD_DRIVE, RST_LOOP_MODE,
            RST_LOOP_SELECT, RST_REF_SELECT, 1'h0}, obs);
        chk("drive ok in reset", 8'h00, {7'h00, ok});
        rst_n_i = 1'h1;
        repeat (2) @(negedge clk_i);
        reset_out_n_i = 1'h1;
        @(negedge clk_i);
        chk("drive ok at release", 8'h00, {7'h00, ok});
        chk("captured config", last_exp, obs);
        repeat (2) @(negedge clk_i);
        chk("drive ok in run", 8'h01, {7'h00, ok});
        chk("held config", last_exp, obs);
    endtask

    task automatic t_strap_table();
        for (int i = 0; i < 4; i++) begin
            boot(1'h0, table_emu[i], table_s[i]);
        end
    endtask

    task automatic t_no_override();
        boot(1'h1, 1'h1, 6'h38);
    endtask

    // Reset-out pulsing again in run must not reopen the capture.
    task automatic t_late_reset_out();
        boot(1'h0, 1'h0, 6'h25);
        model_value = 6'h1A;
        reset_out_n_i = 1'h0;
        repeat (3) @(negedge clk_i);
        reset_out_n_i = 1'h1;
        repeat (2) @(negedge clk_i);
        chk("config after late reset-out", last_exp, obs);
    endtask

    task automatic t_writes();
        boot(1'h0, 1'h1, 6'h3B);
        sel_wr = 1'h1;
        sel_wdata = 3'h5;
        @(negedge clk_i);
        chk("select write one", {3'h5, last_exp[4:0]}, obs);
        sel_wdata = 3'h2;
        @(negedge clk_i);
        sel_wr = 1'h0;
        chk("select write two", {3'h2, last_exp[4:0]}, obs);
        pad_wr = 1'h1;
        pad_wdata = ~last_exp[4];
        @(negedge clk_i);
        pad_wr = 1'h0;
        chk("pad write", {3'h2, ~last_exp[4], last_exp[3:0]}, obs);
        @(negedge clk_i);
        chk("clock mode kept", {4'h0, last_exp[3:0]},
            {4'h0, obs[3:0]});
    endtask

    initial begin
        repeat (5) @(negedge clk_i);
        t_strap_table();
        t_no_override();
        t_late_reset_out();
        t_writes();
        results();
    end
endmodule
